// ==== hw/return_and_rotate_exec.sv ====
// execution of return from interrupt, literal return and rotate left
//
// Function
// - interrupt return pops stack into program counter
// - interrupt return sets global interrupt enable
// - interrupt return: one word, two cycles
// - literal return loads literal into working register
// - literal return pops stack into program counter
// - literal return: one word, two cycles
// - rotate left through carry, nine bits
// - destination bit picks working or file register
`timescale 1ns/10ps
`default_nettype none

`include "rrexec_regs.svh"

module return_and_rotate_exec
  import rrexec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [`RRX_INSN_W-1:0] instr,
  input wire logic [7:0] file_rd_data,
  input wire logic push_valid,
  input wire logic [`RRX_PC_W-1:0] push_addr,
  input wire logic int_enable_clear,
  output logic ready_q,
  output logic [`RRX_PC_W-1:0] pc_q,
  output logic [`RRX_SP_W-1:0] sp_q,
  output logic [7:0] w_q,
  output status_t status_q,
  output logic [7:0] interrupt_control_reg_q,
  output file_wr_t file_wr_q
);

  exec_state_t state_q;
  logic [`RRX_PC_W-1:0] stack_mem [`RRX_STACK_DEPTH];
  logic [`RRX_PC_W-1:0] stack_top_entry;
  logic [`RRX_SP_W-1:0] sp_dec;
  logic accept;
  logic return_from_interrupt_op;
  logic return_with_literal_op;
  logic rotate_left_carry_op;
  logic dest_file;
  logic [7:0] rot_result;
  logic rot_carry;

  // an instruction is only taken outside the flush cycle of a return
  assign accept = instr_valid && (state_q == st_exec);

  assign return_from_interrupt_op = (instr == `RRX_OP_RFI);
  assign return_with_literal_op =
    ((instr & `RRX_OP_RLW_MASK) == `RRX_OP_RLW);
  assign rotate_left_carry_op =
    ((instr & `RRX_OP_RLC_MASK) == `RRX_OP_RLC);
  assign dest_file = instr[`RRX_DEST_BIT];

  // sp points at the next free slot, so the top sits one below
  assign sp_dec = sp_q - `RRX_SP_W'(1);
  assign stack_top_entry = stack_mem[sp_dec];

  rotate_unit #(
    .WIDTH(8)
  ) u_rotate (
    .data_in(file_rd_data),
    .carry_in(status_q.c),
    .data_out(rot_result),
    .carry_out(rot_carry)
  );

  // a return spends its second cycle here, refilling the pipeline
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_exec;
      ready_q <= 1'b1;
    end else begin
      unique case (state_q)
        st_exec: begin
          if (accept &&
              (return_from_interrupt_op || return_with_literal_op)) begin
            state_q <= st_flush;
            ready_q <= 1'b0;
          end
        end
        st_flush: begin
          state_q <= st_exec;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // program counter: returns load the popped top, others step by one word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= `RRX_PC_RST;
    end else if (accept) begin
      if (return_from_interrupt_op || return_with_literal_op) begin
        pc_q <= stack_top_entry;
      end else begin
        pc_q <= pc_q + `RRX_PC_W'(1);
      end
    end
  end

  // stack pointer wraps silently; over- and underflow are not trapped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= '0;
    end else if (accept &&
                 (return_from_interrupt_op || return_with_literal_op)) begin
      sp_q <= sp_dec;
    end else if (push_valid) begin
      sp_q <= sp_q + `RRX_SP_W'(1);
    end
  end

  // a pop in the same cycle wins, so the push is dropped then
  always_ff @(posedge ref_clk) begin
    if (push_valid && !(accept &&
        (return_from_interrupt_op || return_with_literal_op))) begin
      stack_mem[sp_q] <= push_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_q <= `RRX_W_RST;
    end else if (accept && return_with_literal_op) begin
      w_q <= instr[`RRX_LIT_MSB:0];
    end else if (accept && rotate_left_carry_op && !dest_file) begin
      w_q <= rot_result;
    end
  end

  // only the rotate touches status, and only the carry
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
    end else if (accept && rotate_left_carry_op) begin
      status_q.c <= rot_carry;
    end
  end

  // the return sets the enable even if an interrupt entry clears it now
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_control_reg_q <= `RRX_INT_CTRL_RST;
    end else if (accept && return_from_interrupt_op) begin
      interrupt_control_reg_q[`RRX_INT_EN_BIT] <= 1'b1;
    end else if (int_enable_clear) begin
      interrupt_control_reg_q[`RRX_INT_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr_q <= '0;
    end else begin
      file_wr_q.valid <= accept && rotate_left_carry_op && dest_file;
      file_wr_q.addr <= instr[`RRX_FADDR_MSB:0];
      file_wr_q.data <= rot_result;
    end
  end

  property p_rfi_pc;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_from_interrupt_op) |=>
      (pc_q == $past(stack_top_entry)) && (sp_q == $past(sp_dec));
  endproperty
  a_rfi_pc: assert property (p_rfi_pc)
    else $error("interrupt return did not pop the stack into pc");

  property p_rfi_irq_en;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_from_interrupt_op) |=>
      interrupt_control_reg_q[`RRX_INT_EN_BIT];
  endproperty
  a_rfi_irq_en: assert property (p_rfi_irq_en)
    else $error("interrupt return left interrupts disabled");

  property p_rfi_cycles;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_from_interrupt_op) |=> !ready_q ##1 ready_q;
  endproperty
  a_rfi_cycles: assert property (p_rfi_cycles)
    else $error("interrupt return did not take two cycles");

  property p_rlw_w;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_with_literal_op) |=>
      w_q == $past(instr[`RRX_LIT_MSB:0]);
  endproperty
  a_rlw_w: assert property (p_rlw_w)
    else $error("literal return did not load the literal");

  property p_rlw_pc;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_with_literal_op) |=>
      (pc_q == $past(stack_top_entry)) && (sp_q == $past(sp_dec));
  endproperty
  a_rlw_pc: assert property (p_rlw_pc)
    else $error("literal return did not pop the stack into pc");

  property p_rlw_cycles;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && return_with_literal_op) |=>
      !ready_q ##1 (ready_q && $stable(pc_q));
  endproperty
  a_rlw_cycles: assert property (p_rlw_cycles)
    else $error("literal return did not take two cycles");

  property p_rot_value;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && rotate_left_carry_op) |=>
      ($past(dest_file) ? file_wr_q.data : w_q) ==
      {$past(file_rd_data[6:0]), $past(status_q.c)};
  endproperty
  a_rot_value: assert property (p_rot_value)
    else $error("rotate result is wrong");

  property p_rot_dest;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && rotate_left_carry_op) |=>
      (file_wr_q.valid == $past(dest_file)) &&
      ($past(dest_file) ? (w_q == $past(w_q)) : 1'b1);
  endproperty
  a_rot_dest: assert property (p_rot_dest)
    else $error("rotate result went to the wrong place");

  property p_rot_carry;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && rotate_left_carry_op) |=>
      (status_q.c == $past(file_rd_data[7])) &&
      $stable(status_q.z) && $stable(status_q.dc);
  endproperty
  a_rot_carry: assert property (p_rot_carry)
    else $error("rotate carry or other flags wrong");

  property p_ret_flags;
    @(posedge ref_clk) disable iff (!rst_b)
    (accept && (return_from_interrupt_op || return_with_literal_op)) |=>
      $stable(status_q) ##1 $stable(status_q);
  endproperty
  a_ret_flags: assert property (p_ret_flags)
    else $error("a return changed the status flags");

endmodule

`default_nettype wire

// ==== hw/rotate_unit.sv ====
// rotate of a word left by one position through a carry bit
`timescale 1ns/10ps
`default_nettype none

module rotate_unit #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data_in,
  input wire logic carry_in,
  output logic [WIDTH-1:0] data_out,
  output logic carry_out
);

  // carry enters the bottom, the top bit leaves as carry
  assign data_out = {data_in[WIDTH-2:0], carry_in};
  assign carry_out = data_in[WIDTH-1];

endmodule

`default_nettype wire

// ==== hw/rrexec_pkg.sv ====
// types shared by the return and rotate execution block
package rrexec_pkg;

  typedef enum logic [0:0] {
    st_exec = 1'b0,
    st_flush = 1'b1
  } exec_state_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } status_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

endpackage

// ==== hw/rrexec_regs.svh ====
// constants for the return and rotate execution block
`ifndef RREXEC_REGS_SVH
`define RREXEC_REGS_SVH

`define RRX_PC_W 15
`define RRX_INSN_W 14
`define RRX_STACK_DEPTH 16
`define RRX_SP_W 4

// opcode patterns and masks
`define RRX_OP_RFI 14'h0009
`define RRX_OP_RLW_MASK 14'h3F00
`define RRX_OP_RLW 14'h3400
`define RRX_OP_RLC_MASK 14'h3F00
`define RRX_OP_RLC 14'h0D00

// field positions
`define RRX_DEST_BIT 7
`define RRX_FADDR_MSB 6
`define RRX_LIT_MSB 7
`define RRX_INT_EN_BIT 7

// reset values
`define RRX_PC_RST 15'h0000
`define RRX_W_RST 8'h00
`define RRX_INT_CTRL_RST 8'h00

// instruction cycles taken by either return
`define RRX_RETURN_CYCLES 2

`endif

// ==== tb/return_and_rotate_exec_bench.sv ====
// self-checking bench for the return and rotate execution block
`timescale 1ns/10ps
`default_nettype none

`include "rrexec_regs.svh"

module return_and_rotate_exec_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rd_data = 8'h00;
  logic push_valid = 1'b0;
  logic [14:0] push_addr = 15'h0000;
  logic int_enable_clear = 1'b0;
  logic ready_q;
  logic [14:0] pc_q;
  logic [3:0] sp_q;
  logic [7:0] w_q;
  logic [2:0] status_q;
  logic [7:0] irq_ctrl_q;
  logic [15:0] file_wr_q;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  return_and_rotate_exec return_and_rotate_exec_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .file_rd_data(file_rd_data), .push_valid(push_valid),
    .push_addr(push_addr),
    .int_enable_clear(int_enable_clear), .ready_q(ready_q),
    .pc_q(pc_q), .sp_q(sp_q), .w_q(w_q), .status_q(status_q),
    .interrupt_control_reg_q(irq_ctrl_q), .file_wr_q(file_wr_q)
  );

  always #2 ref_clk = ~ref_clk;

  task automatic summarize;
    $display("compared %0d, mismatched %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles >= 1000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic core(input logic [14:0] pc, input logic [3:0] sp,
                      input logic [7:0] w, input logic [7:0] ic,
                      input logic [2:0] st, input logic rdy);
    chk(16'(pc_q), 16'(pc));
    chk(16'(sp_q), 16'(sp));
    chk(16'(w_q), 16'(w));
    chk(16'(irq_ctrl_q), 16'(ic));
    chk(16'(status_q), 16'(st));
    chk(16'(ready_q), 16'(rdy));
  endtask

  // one instruction; results are settled just after the edge that takes it
  task automatic exec(input logic [13:0] op, input logic [7:0] fd,
                      input logic gc);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= op;
    file_rd_data <= fd;
    int_enable_clear <= gc;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    int_enable_clear <= 1'b0;
    #1;
  endtask

  task automatic t_rfi;
    @(posedge ref_clk);
    push_valid <= 1'b1;
    push_addr <= 15'h1234;
    @(posedge ref_clk);
    push_addr <= 15'h0ABC;
    @(posedge ref_clk);
    push_valid <= 1'b0;
    #1;
    chk(16'(sp_q), 16'h0002);
    exec(`RRX_OP_RFI, 8'h00, 1'b0);
    core(15'h0ABC, 4'h1, 8'h00, 8'h80, 3'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(16'(ready_q), 16'h0001);
    exec(14'h0000, 8'h00, 1'b1);
    core(15'h0ABD, 4'h1, 8'h00, 8'h00, 3'b000, 1'b1);
    // clear and return on one edge: the return must win
    exec(`RRX_OP_RFI, 8'h00, 1'b1);
    core(15'h1234, 4'h0, 8'h00, 8'h80, 3'b000, 1'b0);
    $display("test rfi done");
  endtask

  task automatic t_rlw;
    @(posedge ref_clk);
    push_valid <= 1'b1;
    push_addr <= 15'h0155;
    @(posedge ref_clk);
    push_valid <= 1'b0;
    instr_valid <= 1'b1;
    instr <= `RRX_OP_RLW | 14'h00A5;
    @(posedge ref_clk);
    // a rotate offered in the dead cycle must be ignored
    instr <= `RRX_OP_RLC | 14'h0015;
    file_rd_data <= 8'hFF;
    #1;
    core(15'h0155, 4'h0, 8'hA5, 8'h80, 3'h0, 1'b0);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    core(15'h0155, 4'h0, 8'hA5, 8'h80, 3'b000, 1'b1);
    $display("test rlw done");
  endtask

  task automatic t_rlc;
    logic [13:0] ops [3] = '{14'h0D15, 14'h0DAA, 14'h0D00};
    logic [7:0] din [3] = '{8'hE6, 8'h81, 8'h00};
    logic [7:0] res [3] = '{8'hCC, 8'h03, 8'h01};
    logic [7:0] wexp [3] = '{8'hCC, 8'hCC, 8'h01};
    logic cexp [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      exec(ops[i], din[i], 1'b0);
      chk(16'(pc_q), 16'(15'h0156 + i));
      chk(16'(w_q), 16'(wexp[i]));
      chk(16'(status_q), {15'h0000, cexp[i]});
      chk(16'(file_wr_q[15]), 16'(ops[i][7]));
      if (ops[i][7])
        chk(file_wr_q, {1'b1, ops[i][6:0], res[i]});
      @(posedge ref_clk);
      #1;
      chk(16'(file_wr_q[15]), 16'h0000);
    end
    $display("test rlc done");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    core(15'h0000, 4'h0, 8'h00, 8'h00, 3'b000, 1'b1);
    t_rfi();
    t_rlw();
    t_rlc();
    summarize();
  end
endmodule

`default_nettype wire
